// >>> shared/base_timer_pkg.sv
// Purpose: constants shared by the base timer design
// Assumes: 32-bit AXI4-Lite register access, word aligned
// Notes: offsets are byte addresses
package base_timer_pkg;
   // register offsets
   localparam logic [7:0] control_offset = 8'h00;
   localparam logic [7:0] compare_offset = 8'h04;
   localparam logic [7:0] count_offset = 8'h08;
   localparam logic [7:0] status_offset = 8'h0C;
   localparam logic [7:0] prescale_offset = 8'h10;
   // control field positions
   localparam int global_start_bit = 0;
   localparam int group_start_bit = 1;
   localparam int match_reset_bit = 2;
   localparam int pin_reset_enable_bit = 3;
   localparam int pin_select_bit = 4;
   localparam int mode_lo_bit = 5;
   localparam int mode_hi_bit = 6;
   // reset values
   localparam logic [31:0] control_reset = 32'h0000_0000;
   localparam logic [15:0] compare_reset = 16'hFFFF;
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [15:0] prescale_reset = 16'h0000;
   // counter limits
   localparam logic [15:0] count_top = 16'hFFFF;
   localparam logic [15:0] count_bottom = 16'h0000;
   // turnaround delay after compare match, in counts
   localparam logic [1:0] match_turn_counts = 2'h2;
   // axi responses
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   // count mode encodings
   typedef enum logic [1:0] {
      mode_up = 2'b00,
      mode_up_down = 2'b01,
      mode_two_phase = 2'b10,
      mode_illegal = 2'b11
   } count_mode_type;
endpackage

// >>> design/base_timer_up_down_counter.sv
// Purpose: 16-bit base timer with up, up/down and two-phase counting
// Assumes: registers reached over AXI4-Lite; pins are asynchronous
// Notes: pins pass two flops before any logic reads them
// Functional notes
// - bits 6:5 select mode, 11 forbidden
// - either start bit set starts counting
// - up/down turns down at FFFFh
// - match reset: turn down two counts later
// - counting down turns up at 0000h
// - low on chosen interrupt pin resets counter
`timescale 1ns/1ps
module base_timer_up_down_counter
   import base_timer_pkg::*;
#(
   parameter int width = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic phase_a_pin,
   input wire logic phase_b_pin
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [31:0] control, next_control; // control bits
   logic [width-1:0] compare_reg_zero, next_compare; // compare register 0
   logic [width-1:0] prescale, next_prescale; // tick divider reload
   logic [width-1:0] count, next_count; // timer value
   logic [width-1:0] divider, next_divider; // tick divider
   logic down, next_down; // counting direction
   logic [1:0] after_match, next_after_match; // counts since compare match
   logic mode_error, next_mode_error; // sticky illegal mode flag
   // bus holding state
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   // synchronisers: first stage read only by second
   logic [3:0] pin_meta, pin_sync, pin_last;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // merge write data under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] result;
      result = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            result[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // decoded controls
   count_mode_type mode;
   logic started, pin_reset, tick, write_go, match_now;
   logic [1:0] phase_now, phase_old;
   assign mode = count_mode_type'({control[mode_hi_bit], control[mode_lo_bit]});
   assign started = control[global_start_bit] | control[group_start_bit];
   assign pin_reset = control[pin_reset_enable_bit] &
      ~(control[pin_select_bit] ? pin_sync[1] : pin_sync[0]);
   assign tick = (divider == '0);
   assign phase_now = pin_sync[3:2];
   assign phase_old = pin_last[3:2];
   assign match_now = (count == compare_reg_zero);
   assign write_go = aw_held & w_held & ~bvalid;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // two flops, then a history stage for edge detection
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pin_meta <= 4'hF;
         pin_sync <= 4'hF;
         pin_last <= 4'hF;
      end else begin
         pin_meta <= {phase_b_pin, phase_a_pin, ext_irq_pin_one, ext_irq_pin_zero};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   // ----------------------------------------
   // counter next state
   // ----------------------------------------
   always_comb begin
      next_count = count;
      next_down = down;
      next_after_match = after_match;
      next_divider = divider;
      next_mode_error = mode_error | (mode == mode_illegal);
      if (started) begin
         next_divider = tick ? prescale : divider - 1'b1;
      end
      if (pin_reset) begin
         next_count = count_bottom;
         next_down = 1'b0;
         next_after_match = '0;
      end else if (started && mode == mode_two_phase) begin
         // quadrature: a leads b counts up
         if (phase_now[0] != phase_old[0]) begin
            if (phase_now[0] != phase_now[1]) begin
               next_count = count + 1'b1;
            end else begin
               next_count = count - 1'b1;
            end
         end
      end else if (started && tick && mode == mode_up) begin
         next_count = count + 1'b1;
      end else if (started && tick && mode == mode_up_down) begin
         if (down) begin
            if (count == count_bottom) begin
               next_down = 1'b0;
               next_count = count + 1'b1;
            end else begin
               next_count = count - 1'b1;
            end
         end else if (control[match_reset_bit] && (match_now || after_match != '0)) begin
            // two counts past match, then down
            if (after_match == match_turn_counts) begin
               next_down = 1'b1;
               next_after_match = '0;
               next_count = count - 1'b1;
            end else begin
               next_after_match = after_match + 1'b1;
               next_count = count + 1'b1;
            end
         end else if (count == count_top) begin
            next_down = 1'b1;
            next_count = count - 1'b1;
         end else begin
            next_count = count + 1'b1;
         end
      end
      // software write of the counter wins last
      if (write_go && aw_addr == count_offset) begin
         next_count = width'(merge(32'(count), w_data, w_strb));
      end
   end

   // ----------------------------------------
   // bus next state
   // ----------------------------------------
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_control = control;
      next_compare = compare_reg_zero;
      next_prescale = prescale;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      // write decode
      if (write_go) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = resp_okay;
         if (aw_addr == control_offset) begin
            next_control = merge(control, w_data, w_strb) & 32'h0000_007F;
         end else if (aw_addr == compare_offset) begin
            next_compare = width'(merge(32'(compare_reg_zero), w_data, w_strb));
         end else if (aw_addr == prescale_offset) begin
            next_prescale = width'(merge(32'(prescale), w_data, w_strb));
         end else if (aw_addr != count_offset && aw_addr != status_offset) begin
            // unmapped write is refused; the counter write is taken above
            next_bresp = resp_slverr;
         end
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // read decode
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = resp_okay;
         next_rdata = 32'h0000_0000;
         if (s_axi_araddr == control_offset) begin
            next_rdata = control;
         end else if (s_axi_araddr == compare_offset) begin
            next_rdata = {16'h0000, compare_reg_zero};
         end else if (s_axi_araddr == count_offset) begin
            next_rdata = {16'h0000, count};
         end else if (s_axi_araddr == status_offset) begin
            next_rdata = {27'h0, mode_error, pin_reset, started, down, 1'b0};
         end else if (s_axi_araddr == prescale_offset) begin
            next_rdata = {16'h0000, prescale};
         end else begin
            next_rresp = resp_slverr;
         end
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         control <= control_reset;
         compare_reg_zero <= compare_reset;
         prescale <= prescale_reset;
         count <= count_reset;
         divider <= prescale_reset;
         down <= 1'b0;
         after_match <= 2'h0;
         mode_error <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= resp_okay;
         rvalid <= 1'b0;
         rresp <= resp_okay;
         rdata <= 32'h0000_0000;
      end else begin
         control <= next_control;
         compare_reg_zero <= next_compare;
         prescale <= next_prescale;
         count <= next_count;
         divider <= next_divider;
         down <= next_down;
         after_match <= next_after_match;
         mode_error <= next_mode_error;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // handshake outputs
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_arready = ~rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;
endmodule

// >>> verification/base_timer_up_down_counter_sva.sv
// Purpose: bus timing checks for the base timer
// Assumes: rising edge clock, asynchronous active high reset
// Notes: bound to every instance of the timer
`timescale 1ns/1ps
module base_timer_sva
   import base_timer_pkg::*;
#(
   parameter int width = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // handshake steps
   // ----------------------------------------
   sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
   property p_b_late; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_r_late; s_rd_take |=> s_axi_rvalid; endproperty
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   property p_aw_block; s_wr_take |=> !s_axi_awready && !s_axi_wready; endproperty
   property p_count_hi; s_rd_take and s_axi_araddr == count_offset |=> s_axi_rdata[31:width] == '0; endproperty
   property p_unmapped; s_rd_take and s_axi_araddr == 8'h14 |=> s_axi_rresp == resp_slverr; endproperty
   a_b_late: assert property (p_b_late) else $error("write answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_r_late: assert property (p_r_late) else $error("read answer late");
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
   a_count_hi: assert property (p_count_hi) else $error("count wider than sixteen");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule
bind base_timer_up_down_counter base_timer_sva #(.width(width)) chk (.*);

// >>> verification/test_base_timer_up_down_counter.sv
// Purpose: self-checking bench for the base timer
// Assumes: prescale 0 ticks every cycle
// Notes: registers reached over AXI4-Lite tasks
`timescale 1ns/1ps
module test_base_timer_up_down_counter
   import base_timer_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_type;
   logic clock = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic ext_irq_pin_zero = 1'b1, ext_irq_pin_one = 1'b1, phase_a_pin = 1'b0, phase_b_pin = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, ws;
   logic [31:0] s_axi_rdata;
   logic [15:0] top;
   int err_total = 0, num_checks = 0, cycles = 0;
   row_type rows[6] = '{'{control_offset, 32'h0, resp_okay}, '{compare_offset, 32'hFFFF, resp_okay},
      '{count_offset, 32'h0, resp_okay}, '{status_offset, 32'h0, resp_okay},
      '{prescale_offset, 32'h0, resp_okay}, '{8'h14, 32'h0, resp_slverr}};
   base_timer_up_down_counter #(.width(16)) dut (.*);
   initial forever #25 clock = ~clock;
   // cycle ceiling cuts a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one write: address and data together, then wait for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      ws = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // one read, data taken at the answering edge
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      foreach (rows[i]) begin
         rd_reg(rows[i].a);
         check("reg value", rows[i].d, rd);
         check("reg resp", {30'h0, rows[i].r}, {30'h0, rs});
      end
      $display("reset values done");
      wr(8'h14, 32'h0);
      check("write resp", {30'h0, resp_slverr}, {30'h0, ws});
      wr(compare_offset, 32'h0000_ABCD);
      s_axi_wstrb <= 4'h2;
      wr(compare_offset, 32'h0000_1200);
      s_axi_wstrb <= 4'hF;
      rd_reg(compare_offset);
      check("byte strobe", 32'h0000_12CD, rd);
      $display("strobe and response done");
      for (int i = 0; i < 2; i++) begin
         wr(count_offset, 32'h0);
         wr(control_offset, 32'h1 << i);
         rd_reg(count_offset);
         top = rd[15:0];
         rd_reg(count_offset);
         check("counting", 32'h1, {31'h0, rd[15:0] > top});
      end
      wr(control_offset, 32'h0);
      check("write ok", {30'h0, resp_okay}, {30'h0, ws});
      rd_reg(count_offset);
      top = rd[15:0];
      repeat (5) @(posedge clock);
      rd_reg(count_offset);
      check("held", {16'h0, top}, rd);
      $display("start and hold done");
      wr(count_offset, 32'hFFFD);
      wr(control_offset, 32'h21);
      repeat (10) @(posedge clock);
      rd_reg(status_offset);
      check("turned down", 32'h1, {31'h0, rd[1]});
      wr(count_offset, 32'h3);
      repeat (10) @(posedge clock);
      rd_reg(status_offset);
      check("turned up", 32'h0, {31'h0, rd[1]});
      $display("up down done");
      wr(control_offset, 32'h0);
      wr(compare_offset, 32'h10);
      wr(prescale_offset, 32'h7);
      wr(count_offset, 32'hC);
      wr(control_offset, 32'h25);
      top = 16'h0;
      repeat (30) begin
         rd_reg(count_offset);
         if (rd[15:0] > top) top = rd[15:0];
      end
      check("match peak", 32'h12, {16'h0, top});
      wr(prescale_offset, 32'h0);
      $display("match turn done");
      for (int p = 0; p < 2; p++) begin
         wr(control_offset, 32'h9 | (p << 4));
         wr(count_offset, 32'h4000);
         if (p == 1) ext_irq_pin_one <= 1'b0;
         else ext_irq_pin_zero <= 1'b0;
         repeat (4) @(posedge clock);
         rd_reg(count_offset);
         check("pin reset", 32'h1, {31'h0, rd[15:0] < 16'h0010});
         rd_reg(status_offset);
         check("pin flag", 32'h0000_000C, rd);
         ext_irq_pin_one <= 1'b1;
         ext_irq_pin_zero <= 1'b1;
      end
      $display("pin reset done");
      wr(control_offset, 32'h0);
      wr(count_offset, 32'h5);
      wr(control_offset, 32'h41);
      for (int k = 0; k < 8; k++) begin
         if (k % 2 == 0) phase_a_pin <= ~phase_a_pin;
         else phase_b_pin <= ~phase_b_pin;
         repeat (5) @(posedge clock);
      end
      rd_reg(count_offset);
      check("two phase", 32'h9, rd);
      wr(control_offset, 32'h61);
      rd_reg(count_offset);
      top = rd[15:0];
      repeat (10) @(posedge clock);
      rd_reg(count_offset);
      check("bad mode holds", {16'h0, top}, rd);
      rd_reg(status_offset);
      check("bad mode flag", 32'h1, {31'h0, rd[4]});
      $display("modes done");
      // reset in mid-run clears the sticky flag, the start bits and the count
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rd_reg(status_offset);
      check("status after reset", 32'h0, rd);
      rd_reg(count_offset);
      check("count after reset", 32'h0, rd);
      $display("mid-run reset done");
      complete_run();
   end
endmodule
